// file: logic/duc_pkg.sv
/*
 Constants for the dual channel pin control block: register indexes, field
 positions, reset values and the sampling figure of the receive vote.
 Assumes an APB master with 32-bit data; each register takes one word.
*/
package duc_pkg;

   // ---------------------------------------------------------------
   // Address layout
   // ---------------------------------------------------------------
   localparam int NCH = 2;
   localparam int ADDR_W = 6;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 3;
   localparam int CH_BIT = 5;

   localparam logic [2:0] REG_IER = 3'h1;
   localparam logic [2:0] REG_EFR = 3'h2;
   localparam logic [2:0] REG_MCR = 3'h4;
   localparam logic [2:0] REG_MSR = 3'h6;
   localparam logic [2:0] REG_TRIG = 3'h7;

   // ---------------------------------------------------------------
   // Fields
   // ---------------------------------------------------------------
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_IRQ_EN = 3;
   localparam int MCR_LOOP = 4;
   localparam int EFR_AUTO_RTS = 6;
   localparam int EFR_AUTO_CTS = 7;
   localparam int IER_MODEM = 3;
   localparam int MSR_RING_EDGE = 2;
   localparam int MSR_RING = 6;
   localparam int TRIG_RX_LSB = 0;
   localparam int TRIG_TX_LSB = 4;
   localparam int TRIG_W = 4;

   // ---------------------------------------------------------------
   // Reset values and sampling
   // ---------------------------------------------------------------
   localparam logic [7:0] IER_RST = 8'h00;
   localparam logic [7:0] EFR_RST = 8'h00;
   localparam logic [7:0] MCR_RST = 8'h00;
   localparam logic [7:0] TRIG_RST = 8'h11;
   localparam logic [1:0] VOTE_LAST = 2'h2;
   localparam logic [2:0] VOTE_IDLE = 3'h7;

endpackage : duc_pkg

// file: logic/duc_channel_pins.sv
/*
 Pin control of a two channel serial transceiver: APB register access,
 modem handshake pins, interrupt pin with its enable, DMA ready pins,
 local loopback and three sample majority vote on the receive line.
 Assumes the character engine and its queues sit outside and report their
 fill levels, timeout, error and interrupt request synchronous to pclk.
*/
`timescale 1ns/1ns

// How it works
// - Write data lands in addressed channel register
// - Interrupt enable bit set: drive irq, output low
// - Enable bit clear: irq released, output high
// - Both user outputs high after reset
// - Reset clears IER, EFR, MCR, irq, irq enable, tx allow, vote valid; TRIG gets 11h, other pins high
// - Transmit and receive disabled during reset
// - Ring input rising edge raises modem interrupt
// - Control bit 1 drives request-to-send low
// - Request-to-send high after reset
// - Request-to-send steers flow only when auto
// - Loopback feeds transmit data into receiver
// - Receive ready low at trigger or timeout
// - Receive ready high when empty or error
// - Transmit ready low when free reaches trigger
// - Transmit ready high when buffer full
// - Three samples, majority vote per bit
// - Vote applies to every received bit
// - Read returns addressed register contents
// - Control bit 0 drives terminal-ready low
// - Clear-to-send gates transmit only when auto
// - Irq only when enabled, allowed, pending
module duc_channel_pins #(
   parameter int LVL_W = 7
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [duc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [duc_pkg::NCH-1:0] ring_indicate_n,
   input wire logic [duc_pkg::NCH-1:0] cts_n,
   input wire logic [duc_pkg::NCH-1:0] rx_pin,
   input wire logic [duc_pkg::NCH-1:0] tx_serial,
   input wire logic [duc_pkg::NCH-1:0] rx_sample_tick,
   input wire logic [duc_pkg::NCH-1:0] auto_rts_room,
   input wire logic [duc_pkg::NCH-1:0] core_irq,
   input wire logic [duc_pkg::NCH-1:0] rx_timeout,
   input wire logic [duc_pkg::NCH-1:0] rx_error,
   input wire logic [duc_pkg::NCH*LVL_W-1:0] rx_level,
   input wire logic [duc_pkg::NCH*LVL_W-1:0] tx_free,
   output wire logic [duc_pkg::NCH-1:0] user_output,
   output wire logic [duc_pkg::NCH-1:0] channel_irq,
   output wire logic [duc_pkg::NCH-1:0] channel_irq_oe,
   output wire logic [duc_pkg::NCH-1:0] dtr_n,
   output wire logic [duc_pkg::NCH-1:0] rts_n,
   output wire logic [duc_pkg::NCH-1:0] tx_pin,
   output wire logic [duc_pkg::NCH-1:0] tx_allow,
   output wire logic [duc_pkg::NCH-1:0] rx_voted,
   output wire logic [duc_pkg::NCH-1:0] rx_voted_valid,
   output wire logic [duc_pkg::NCH-1:0] rx_dma_ready_n,
   output wire logic [duc_pkg::NCH-1:0] tx_dma_ready_n
);

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic access;
   logic done;
   logic mapped;
   logic [duc_pkg::IDX_W-1:0] idx;
   logic ch;
   logic [7:0] rd_val [duc_pkg::NCH];

   assign access = psel & penable;
   assign done = access & pready_q;
   assign idx = paddr[duc_pkg::IDX_LSB +: duc_pkg::IDX_W];
   assign ch = paddr[duc_pkg::CH_BIT];
   assign mapped = (idx == duc_pkg::REG_IER) | (idx == duc_pkg::REG_EFR) | (idx == duc_pkg::REG_MCR) |
                   (idx == duc_pkg::REG_MSR) | (idx == duc_pkg::REG_TRIG);

   // One wait state so read data comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else if (ce) begin
         pready_q <= access & ~pready_q;
      end
   end

   // Error flag rides with pready; unmapped writes are dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_q <= 1'b0;
      end else if (ce) begin
         if (access & ~pready_q) begin
            pslverr_q <= ~mapped;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (ce) begin
         if (access & ~pready_q) begin
            if (!pwrite && mapped) begin
               prdata_q <= {24'h0, rd_val[ch]};
            end else begin
               prdata_q <= 32'h0;
            end
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ---------------------------------------------------------------
   // Per channel logic
   // ---------------------------------------------------------------
   for (genvar g = 0; g < duc_pkg::NCH; g++) begin : g_ch
      logic [7:0] ier_q;
      logic [7:0] efr_q;
      logic [7:0] mcr_q;
      logic [7:0] trig_q;
      logic ring_prev_q;
      logic ring_edge_q;
      logic user_q;
      logic irq_q;
      logic irq_oe_q;
      logic dtr_q;
      logic rts_q;
      logic tx_q;
      logic allow_q;
      logic [2:0] samp_q;
      logic [1:0] cnt_q;
      logic vote_q;
      logic vote_vld_q;
      logic rxr_q;
      logic txr_q;
      logic sel;
      logic wr;
      logic msr_rd;
      logic ring_rise;
      logic rx_in;
      logic [LVL_W-1:0] rx_lvl;
      logic [LVL_W-1:0] tx_fr;
      logic [LVL_W-1:0] rx_trig;
      logic [LVL_W-1:0] tx_trig;

      assign sel = (ch == 1'(g));
      assign wr = done & pwrite & mapped & sel;
      assign msr_rd = done & ~pwrite & sel & (idx == duc_pkg::REG_MSR);
      assign ring_rise = ring_indicate_n[g] & ~ring_prev_q;
      assign rx_lvl = rx_level[g*LVL_W +: LVL_W];
      assign tx_fr = tx_free[g*LVL_W +: LVL_W];
      assign rx_trig = LVL_W'(trig_q[duc_pkg::TRIG_RX_LSB +: duc_pkg::TRIG_W]);
      assign tx_trig = LVL_W'(trig_q[duc_pkg::TRIG_TX_LSB +: duc_pkg::TRIG_W]);

      // -------------------------------------------------------------
      // Registers
      // -------------------------------------------------------------
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ier_q <= duc_pkg::IER_RST;
            efr_q <= duc_pkg::EFR_RST;
            mcr_q <= duc_pkg::MCR_RST;
            trig_q <= duc_pkg::TRIG_RST;
         end else if (ce && wr) begin
            case (idx)
               duc_pkg::REG_IER: ier_q <= pwdata[7:0];
               duc_pkg::REG_EFR: efr_q <= pwdata[7:0];
               duc_pkg::REG_MCR: mcr_q <= pwdata[7:0];
               duc_pkg::REG_TRIG: trig_q <= pwdata[7:0];
               default: ier_q <= ier_q;
            endcase
         end
      end

      // Sticky ring edge; a new edge beats the read that clears it
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ring_prev_q <= 1'b0;
            ring_edge_q <= 1'b0;
         end else if (ce) begin
            ring_prev_q <= ring_indicate_n[g];
            if (ring_rise) begin
               ring_edge_q <= 1'b1;
            end else if (msr_rd) begin
               ring_edge_q <= 1'b0;
            end
         end
      end

      always_comb begin
         rd_val[g] = 8'h00;
         case (idx)
            duc_pkg::REG_IER: rd_val[g] = ier_q;
            duc_pkg::REG_EFR: rd_val[g] = efr_q;
            duc_pkg::REG_MCR: rd_val[g] = mcr_q;
            duc_pkg::REG_TRIG: rd_val[g] = trig_q;
            duc_pkg::REG_MSR: begin
               rd_val[g][duc_pkg::MSR_RING] = ~ring_prev_q;
               rd_val[g][duc_pkg::MSR_RING_EDGE] = ring_edge_q;
            end
            default: rd_val[g] = 8'h00;
         endcase
      end

      // -------------------------------------------------------------
      // Modem and interrupt pins
      // -------------------------------------------------------------
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            user_q <= 1'b1;
            irq_q <= 1'b0;
            irq_oe_q <= 1'b0;
         end else if (ce) begin
            user_q <= ~mcr_q[duc_pkg::MCR_IRQ_EN];
            irq_oe_q <= mcr_q[duc_pkg::MCR_IRQ_EN];
            irq_q <= mcr_q[duc_pkg::MCR_IRQ_EN] &
                     (core_irq[g] | (ier_q[duc_pkg::IER_MODEM] & ring_edge_q));
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            dtr_q <= 1'b1;
            rts_q <= 1'b1;
         end else if (ce) begin
            dtr_q <= ~mcr_q[duc_pkg::MCR_DTR];
            if (efr_q[duc_pkg::EFR_AUTO_RTS]) begin
               rts_q <= ~(mcr_q[duc_pkg::MCR_RTS] & auto_rts_room[g]);
            end else begin
               rts_q <= ~mcr_q[duc_pkg::MCR_RTS];
            end
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            allow_q <= 1'b0;
         end else if (ce) begin
            allow_q <= ~efr_q[duc_pkg::EFR_AUTO_CTS] | ~cts_n[g];
         end
      end

      // -------------------------------------------------------------
      // Serial path, loopback and vote
      // -------------------------------------------------------------
      // Loopback keeps the pin at mark so the far end sees idle line
      assign rx_in = mcr_q[duc_pkg::MCR_LOOP] ? tx_serial[g] : rx_pin[g];

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            tx_q <= 1'b1;
         end else if (ce) begin
            tx_q <= mcr_q[duc_pkg::MCR_LOOP] | tx_serial[g];
         end
      end

      // Three ticks per bit; the engine spaces them around mid-bit
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            samp_q <= duc_pkg::VOTE_IDLE;
            cnt_q <= 2'h0;
            vote_q <= 1'b1;
            vote_vld_q <= 1'b0;
         end else if (ce) begin
            vote_vld_q <= 1'b0;
            if (rx_sample_tick[g]) begin
               samp_q <= {samp_q[1:0], rx_in};
               if (cnt_q == duc_pkg::VOTE_LAST) begin
                  cnt_q <= 2'h0;
                  vote_q <= (samp_q[1] & samp_q[0]) | (samp_q[1] & rx_in) |
                            (samp_q[0] & rx_in);
                  vote_vld_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q + 2'h1;
               end
            end
         end
      end

      // -------------------------------------------------------------
      // DMA ready pins
      // -------------------------------------------------------------
      // Empty or error outranks trigger so a bad byte is never fetched blind
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rxr_q <= 1'b1;
         end else if (ce) begin
            if (rx_lvl == '0 || rx_error[g]) begin
               rxr_q <= 1'b1;
            end else if (rx_lvl >= rx_trig || rx_timeout[g]) begin
               rxr_q <= 1'b0;
            end
         end
      end

      // Full outranks trigger, as on the receive side
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            txr_q <= 1'b1;
         end else if (ce) begin
            if (tx_fr == '0) begin
               txr_q <= 1'b1;
            end else if (tx_fr >= tx_trig) begin
               txr_q <= 1'b0;
            end
         end
      end

      assign user_output[g] = user_q;
      assign channel_irq[g] = irq_q;
      assign channel_irq_oe[g] = irq_oe_q;
      assign dtr_n[g] = dtr_q;
      assign rts_n[g] = rts_q;
      assign tx_pin[g] = tx_q;
      assign tx_allow[g] = allow_q;
      assign rx_voted[g] = vote_q;
      assign rx_voted_valid[g] = vote_vld_q;
      assign rx_dma_ready_n[g] = rxr_q;
      assign tx_dma_ready_n[g] = txr_q;
   end

endmodule : duc_channel_pins

// file: verif/duc_pins_sva.sv
/*
 Checker for duc_channel_pins: APB wait state, pin relations, vote timing.
 Assumes ce high whenever antecedents count; attached by the bind below.
*/
`timescale 1ns/1ns
module duc_pins_sva #(
   parameter int LVL_W = 7
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic [1:0] cts_n,
   input wire logic [1:0] tx_allow,
   input wire logic [1:0] user_output,
   input wire logic [1:0] channel_irq,
   input wire logic [1:0] channel_irq_oe,
   input wire logic [1:0] rts_n,
   input wire logic [2*LVL_W-1:0] rx_level,
   input wire logic [1:0] rx_error,
   input wire logic [2*LVL_W-1:0] tx_free,
   input wire logic [1:0] rx_dma_ready_n,
   input wire logic [1:0] tx_dma_ready_n,
   input wire logic [1:0] rx_sample_tick,
   input wire logic [1:0] rx_voted_valid
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc;
      ce && psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   property p_apb;
      s_acc |=> s_answer;
   endproperty
   a_apb: assert property (p_apb) else $error("pready timing wrong");
   property p_uo;
      user_output == ~channel_irq_oe;
   endproperty
   a_uo: assert property (p_uo) else $error("user output vs irq enable");
   property p_irq;
      (channel_irq & ~channel_irq_oe) == 2'h0;
   endproperty
   a_irq: assert property (p_irq) else $error("irq while released");
   property p_rst;
      $rose(presetn) |-> user_output == 2'h3 && rts_n == 2'h3;
   endproperty
   a_rst: assert property (p_rst) else $error("pins after reset");
   property p_cts;
      ce |=> (~$past(cts_n) & ~tx_allow) == 2'h0;
   endproperty
   a_cts: assert property (p_cts) else $error("tx blocked with cts");
   property p_rxr;
      ce && (rx_level[LVL_W-1:0] == '0 || rx_error[0]) |=> rx_dma_ready_n[0];
   endproperty
   a_rxr: assert property (p_rxr) else $error("rx ready not high");
   property p_txr;
      ce && tx_free[LVL_W-1:0] == '0 |=> tx_dma_ready_n[0];
   endproperty
   a_txr: assert property (p_txr) else $error("tx ready not high");
   property p_vote;
      rx_voted_valid[0] && $past(ce) |-> $past(rx_sample_tick[0]);
   endproperty
   a_vote: assert property (p_vote) else $error("vote without tick");
endmodule : duc_pins_sva

bind duc_channel_pins duc_pins_sva #(.LVL_W(LVL_W)) i_duc_pins_sva (.pclk(pclk), .presetn(presetn), .ce(ce),
   .psel(psel), .penable(penable), .pready(pready), .cts_n(cts_n), .tx_allow(tx_allow),
   .user_output(user_output), .channel_irq(channel_irq), .channel_irq_oe(channel_irq_oe), .rts_n(rts_n),
   .rx_level(rx_level), .rx_error(rx_error), .tx_free(tx_free), .rx_dma_ready_n(rx_dma_ready_n),
   .tx_dma_ready_n(tx_dma_ready_n), .rx_sample_tick(rx_sample_tick), .rx_voted_valid(rx_voted_valid));

// file: verif/duc_line_model.sv
/*
 Serial line model: three samples per bit on channel 0, inverse on 1.
 Assumes the bench sets samp; one tick every second cycle.
*/
`timescale 1ns/1ns
module duc_line_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] samp,
   output logic [1:0] rx_pin,
   output logic [1:0] rx_sample_tick
);
   logic [2:0] ph_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_q <= 3'h0;
      end else begin
         ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
      end
   end
   // Level held two cycles so each tick sees a settled sample
   assign rx_pin = {~samp[ph_q[2:1]], samp[ph_q[2:1]]};
   assign rx_sample_tick = {2{ph_q[0]}};
endmodule : duc_line_model

// file: verif/duc_channel_pins_tb.sv
/*
 Bench for duc_channel_pins: APB tasks, control rows, hand tests.
 Assumes duc_line_model drives the receive side; ce tied high, core_irq driven by the bench.
*/
`timescale 1ns/1ns
module duc_channel_pins_tb;
   typedef struct {logic [7:0] ctl; logic [3:0] pins;} duc_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [5:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] ri_n, cts_n, rx_pin, tx_ser, tick, room, rx_to, rx_err, cirq;
   logic [1:0] uo, irq, oe, dtr_n, rts_n, tx_pin, tx_ok, rxv, rxv_ok, rrdy_n, trdy_n;
   logic [13:0] rx_level, tx_free;
   logic [2:0] samp;
   logic [2:0] vs[4] = '{3'h6, 3'h1, 3'h5, 3'h2};
   int fail_count, checks, cyc, n;
   duc_row_t rows[5] = '{'{8'h00, 4'hb}, '{8'h0b, 4'h4}, '{8'h01, 4'h9}, '{8'h02, 4'ha}, '{8'h08, 4'h7}};
   duc_channel_pins i_duc_channel_pins (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ring_indicate_n(ri_n), .cts_n(cts_n), .rx_pin(rx_pin), .tx_serial(tx_ser),
      .rx_sample_tick(tick), .auto_rts_room(room), .core_irq(cirq), .rx_timeout(rx_to), .rx_error(rx_err),
      .rx_level(rx_level), .tx_free(tx_free), .user_output(uo), .channel_irq(irq), .channel_irq_oe(oe),
      .dtr_n(dtr_n), .rts_n(rts_n), .tx_pin(tx_pin), .tx_allow(tx_ok), .rx_voted(rxv),
      .rx_voted_valid(rxv_ok), .rx_dma_ready_n(rrdy_n), .tx_dma_ready_n(trdy_n));
   duc_line_model i_duc_line_model (.pclk(pclk), .presetn(presetn), .samp(samp), .rx_pin(rx_pin),
      .rx_sample_tick(tick));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wt(input int k);
      repeat (k) @(posedge pclk);
   endtask : wt
   task automatic apb(input logic w, input logic c, input logic [2:0] r, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {c, r, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wv();
      n = 0;
      do @(posedge pclk); while (rxv_ok[0] !== 1'b1 && ++n < 20);
      chk("vote valid", 32'h1, {31'h0, rxv_ok[0]});
   endtask : wv
   function automatic logic maj(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : maj
   task automatic give_verdict();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   // ---------------------------------------------------------------
   // Clock, timeout, sequence
   // ---------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 4000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, room, rx_to, rx_err, cirq, rx_level, tx_free} = '0;
      {ri_n, cts_n, tx_ser, samp} = 9'h1ff;
      presetn = 1'b0;
      wt(12);
      chk("rst pins", 32'h3f, {uo, rts_n, dtr_n});
      chk("rst out", 32'h3f, {oe, tx_ok, tx_pin, rrdy_n, trdy_n});
      presetn <= 1'b1;
      wt(2);
      apb(0, 0, duc_pkg::REG_MSR, 8'h00);
      apb(0, 0, duc_pkg::REG_TRIG, 8'h00);
      chk("trig", {24'h0, duc_pkg::TRIG_RST}, rd);
      apb(1, 0, 3'h0, 8'h5a);
      chk("unmapped", 32'h1, {31'h0, err});
      foreach (rows[i]) begin
         apb(1, 0, duc_pkg::REG_MCR, rows[i].ctl);
         wt(1);
         chk("pins", {28'h0, rows[i].pins}, {uo[0], oe[0], dtr_n[0], rts_n[0]});
         apb(0, 0, duc_pkg::REG_MCR, 8'h00);
         chk("ctl rd", {24'h0, rows[i].ctl}, rd);
      end
      apb(1, 0, duc_pkg::REG_IER, 8'h08);
      ri_n[0] <= 1'b0;
      wt(3);
      ri_n[0] <= 1'b1;
      wt(4);
      chk("ring irq", 32'h1, {31'h0, irq[0]});
      apb(0, 0, duc_pkg::REG_MSR, 8'h00);
      chk("ring flag", 32'h4, rd & 32'h4);
      wt(3);
      chk("irq clr", 32'h0, {31'h0, irq[0]});
      apb(1, 1, duc_pkg::REG_EFR, 8'hc0);
      apb(1, 1, duc_pkg::REG_MCR, 8'h02);
      wt(1);
      chk("auto halt", 32'h2, {rts_n[1], tx_ok[1]});
      room <= 2'h2;
      cts_n <= 2'h1;
      wt(2);
      chk("auto go", 32'h1, {rts_n[1], tx_ok[1]});
      cirq <= 2'h2;
      wt(2);
      chk("irq gated", 32'h0, {30'h0, oe[1], irq[1]});
      apb(1, 1, duc_pkg::REG_MCR, 8'h0a);
      wt(1);
      chk("core irq", 32'h3, {30'h0, oe[1], irq[1]});
      apb(1, 0, duc_pkg::REG_TRIG, 8'h44);
      rx_level <= 14'h2;
      tx_free <= 14'h2;
      wt(2);
      chk("dma hold", 32'h3, {rrdy_n[0], trdy_n[0]});
      rx_to <= 2'h1;
      tx_free <= 14'h4;
      wt(2);
      chk("dma low", 32'h0, {rrdy_n[0], trdy_n[0]});
      rx_to <= 2'h0;
      rx_err <= 2'h1;
      tx_free <= 14'h0;
      wt(2);
      chk("dma err", 32'h3, {rrdy_n[0], trdy_n[0]});
      rx_err <= 2'h0;
      rx_level <= 14'h4;
      wt(2);
      chk("rx trig", 32'h0, {31'h0, rrdy_n[0]});
      rx_level <= 14'h0;
      wt(2);
      chk("rx empty", 32'h1, {31'h0, rrdy_n[0]});
      foreach (vs[i]) begin
         samp <= vs[i];
         wt(12);
         wv();
         chk("vote", {30'h0, ~maj(vs[i]), maj(vs[i])}, {30'h0, rxv});
      end
      apb(1, 0, duc_pkg::REG_MCR, 8'h10);
      tx_ser <= 2'h2;
      samp <= 3'h7;
      wt(12);
      wv();
      chk("loopback", 32'h2, {tx_pin[0], rxv[0]});
      presetn <= 1'b0;
      wt(2);
      chk("mid rst", 32'hfff0, {uo, rts_n, dtr_n, tx_pin, rrdy_n, trdy_n, oe, tx_ok});
      give_verdict();
   end
endmodule : duc_channel_pins_tb
